/* File: logic/eiu_unit.sv */
`timescale 1ns/100ps
// Behaviour
// - Soft trap opcode raises top-priority exception immediately
// - Unmapped single-chip fetch returns FFH, traps
// - Fetch from RAM/register area raises trap
// - Watchdog setting picks reset or trap interrupt
// - Undefined opcode execution raises its exception
// - Undefined opcode preempts non-maskable service
// - Address trap preempts non-maskable service
// - Three external inputs, each digitally filtered
// - Input zero needs master, flag four, pin select
// - Inputs zero, five: reject 2, accept 7
// - Input one rejects 15 or 63 periods
// - Input one accepts 49 or 193 periods
// - Noise select zero long, one mid
// - Input one edge: zero rising, one falling
// - Pin select chooses port or input zero
// - Port mode blocks latch four setting
// - Clean edge sets latch within bounded time
// - New noise time acts within 64 periods
// - System registers live at 0000H..003FH
// - Master enable gates all maskable requests
module eiu_unit import eiu_pkg::*; #(
  parameter logic [15:0] RAM_TOP = 16'h00FF  // Top of the trapped fetch area
)(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_fetch_valid,
  input  wire logic [15:0] i_fetch_addr,
  input  wire logic        i_fetch_mapped,
  input  wire logic [7:0]  i_fetch_data,
  input  wire logic        i_single_chip,
  input  wire logic        i_op_undefined,
  input  wire logic        i_trap_reset_sel,
  input  wire eiu_exc_s    i_exc_ack,
  input  wire logic        i_irq_ack,
  input  wire logic [2:0]  i_pins_n,
  output logic      [7:0]  o_fetch_byte,
  output eiu_exc_s         o_exc,
  output logic             o_break,
  output logic             o_trap_reset,
  output logic             o_irq_req,
  output logic      [1:0]  o_irq_src,
  output logic             o_pin_is_irq
);

  // ==========================================================
  // State
  eiu_state_s r;    // Registered state
  eiu_state_s nxt;  // Next state

  // Working terms of the combinational process
  logic       sel;     // Access lands in the register window
  logic [7:0] byte_f;  // Byte handed to the core
  logic       soft_trap_opcode;     // Soft trap opcode fetched
  logic       undef;   // Undefined opcode executed
  logic       trap;    // Fetch from trapped area
  logic [7:0] n1;      // Current stable count for input one
  logic [2:0] set;     // Latch set events: 0, 1, 5
  logic [2:0] pend;    // Enabled pending latches

  // ==========================================================
  // One filter step: a level change is taken only after the synchronised
  // pin has stayed at the new level for n sampled periods
  function automatic logic [8:0] filt(input logic s2, input logic s3, input logic lv,
                                      input logic [7:0] c, input logic [7:0] n);
    logic [7:0] c1;
    c1 = c + 8'h01;
    if (s2 != s3 || s3 == lv) begin
      filt = {lv, 8'h00};  // Disagreement or no change restarts
    end else if (c1 >= n) begin
      filt = {s3, 8'h00};  // Held long enough
    end else begin
      filt = {lv, c1};
    end
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt = r;
    // Three-flop synchronisers; s1 feeds only s2
    nxt.s1 = i_pins_n;
    nxt.s2 = r.s1;
    nxt.s3 = r.s2;
    // Count switches straight away, well inside 64 periods
    n1 = r.ctl[EIU_B_NTS] ? EIU_N_MID : EIU_N_LONG;
    // Digital noise filters
    {nxt.lvl[EIU_P0], nxt.cnt0} = filt(r.s2[EIU_P0], r.s3[EIU_P0], r.lvl[EIU_P0],
                                       r.cnt0, EIU_N_SHORT);
    {nxt.lvl[EIU_P1], nxt.cnt1} = filt(r.s2[EIU_P1], r.s3[EIU_P1], r.lvl[EIU_P1],
                                       r.cnt1, n1);
    {nxt.lvl[EIU_P5], nxt.cnt5} = filt(r.s2[EIU_P5], r.s3[EIU_P5], r.lvl[EIU_P5],
                                       r.cnt5, EIU_N_SHORT);
    // Edge detect on the filtered levels
    set[0] = r.lvl[EIU_P0] & ~nxt.lvl[EIU_P0] & r.ctl[EIU_B_PFS];
    set[1] = (r.lvl[EIU_P1] != nxt.lvl[EIU_P1]) &&
             (nxt.lvl[EIU_P1] == ~r.ctl[EIU_B_ES]);
    set[2] = r.lvl[EIU_P5] & ~nxt.lvl[EIU_P5];

    // Register writes, only inside the window
    sel = (i_reg_addr <= EIU_SFR_TOP);
    if (i_reg_wr && sel) begin
      case (i_reg_addr[5:0])
        EIU_A_CTL: begin
          nxt.ctl = i_reg_wdata & EIU_CTL_MASK;
        end
        EIU_A_ENL: begin
          nxt.enl = i_reg_wdata;
        end
        EIU_A_ENH: begin
          nxt.enh = i_reg_wdata;
        end
        EIU_A_LTL: begin
          nxt.ltl = r.ltl & i_reg_wdata;  // Zero clears, one keeps
        end
        EIU_A_LTH: begin
          nxt.lth = r.lth & i_reg_wdata;
        end
        EIU_A_PSW: begin
          nxt.program_status_word = i_reg_wdata;
        end
        default: begin
          nxt.program_status_word = r.program_status_word;  // Other addresses belong elsewhere
        end
      endcase
    end

    // Acceptance clears the source latch and the master enable
    if (i_irq_ack && r.irq) begin
      nxt.enl[EIU_B_IMF] = 1'b0;
      case (r.src)
        EIU_SRC0: begin
          nxt.ltl[EIU_B_EF4] = 1'b0;
        end
        EIU_SRC1: begin
          nxt.ltl[EIU_B_EF5] = 1'b0;
        end
        default: begin
          nxt.lth[EIU_B_ENABLE_FLAG_FIFTEEN] = 1'b0;
        end
      endcase
    end
    // Set beats any clear in the same cycle
    nxt.ltl[EIU_B_EF4]  = nxt.ltl[EIU_B_EF4] | set[0];
    nxt.ltl[EIU_B_EF5]  = nxt.ltl[EIU_B_EF5] | set[1];
    nxt.lth[EIU_B_ENABLE_FLAG_FIFTEEN] = nxt.lth[EIU_B_ENABLE_FLAG_FIFTEEN] | set[2];

    // Maskable request, priority zero, one, five
    pend[0] = r.ltl[EIU_B_EF4] & r.enl[EIU_B_EF4];
    pend[1] = r.ltl[EIU_B_EF5] & r.enl[EIU_B_EF5];
    pend[2] = r.lth[EIU_B_ENABLE_FLAG_FIFTEEN] & r.enh[EIU_B_ENABLE_FLAG_FIFTEEN];
    nxt.irq = r.enl[EIU_B_IMF] & (|pend) & ~(i_irq_ack & r.irq);
    if (pend[0]) begin
      nxt.src = EIU_SRC0;
    end else if (pend[1]) begin
      nxt.src = EIU_SRC1;
    end else begin
      nxt.src = EIU_SRC5;
    end

    // Fetch path: unmapped memory in single chip mode reads as the soft trap opcode
    byte_f = (i_single_chip && !i_fetch_mapped) ? EIU_SOFT_TRAP_OP : i_fetch_data;
    if (i_fetch_valid) begin
      nxt.fbyte = byte_f;
    end
    soft_trap_opcode   = i_fetch_valid && (byte_f == EIU_SOFT_TRAP_OP);
    undef = i_fetch_valid && i_op_undefined && !soft_trap_opcode;
    trap  = i_fetch_valid && (i_fetch_addr <= RAM_TOP);
    // Exceptions ignore masks and any non-maskable service in progress
    nxt.exc.soft_trap_opcode   = (r.exc.soft_trap_opcode & ~i_exc_ack.soft_trap_opcode) | soft_trap_opcode;
    nxt.exc.undef = (r.exc.undef & ~i_exc_ack.undef) | undef;
    nxt.exc.trap  = (r.exc.trap & ~i_exc_ack.trap) | (trap & ~i_trap_reset_sel);
    nxt.trst      = trap & i_trap_reset_sel;
    nxt.brk       = nxt.exc.undef | nxt.exc.trap;

    // Read data, reserved bits as zero
    if (i_reg_rd && sel) begin
      case (i_reg_addr[5:0])
        EIU_A_CTL: begin
          nxt.rdata = r.ctl;
        end
        EIU_A_ENL: begin
          nxt.rdata = r.enl;
        end
        EIU_A_ENH: begin
          nxt.rdata = r.enh;
        end
        EIU_A_LTL: begin
          nxt.rdata = r.ltl;
        end
        EIU_A_LTH: begin
          nxt.rdata = r.lth;
        end
        EIU_A_PSW: begin
          nxt.rdata = r.program_status_word;
        end
        default: begin
          nxt.rdata = EIU_RST_REG;
        end
      endcase
    end
  end

  // ==========================================================
  // State register; pins idle high, pin starts as port input
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r      <= '0;
      r.s1   <= 3'h7;
      r.s2   <= 3'h7;
      r.s3   <= 3'h7;
      r.lvl  <= 3'h7;
      r.src  <= EIU_SRC5;
      r.ctl  <= EIU_RST_REG;
    end else if (i_ce) begin
      r <= nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the state
  assign o_reg_rdata  = r.rdata;
  assign o_fetch_byte = r.fbyte;
  assign o_exc        = r.exc;
  assign o_break      = r.brk;
  assign o_trap_reset = r.trst;
  assign o_irq_req    = r.irq;
  assign o_irq_src    = r.src;
  assign o_pin_is_irq = r.ctl[EIU_B_PFS];

  // ==========================================================
  // Checks
  property p_swi;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && i_fetch_valid && i_fetch_data == EIU_SOFT_TRAP_OP |=> o_exc.soft_trap_opcode;
  endproperty
  a_swi: assert property (p_swi) else $error("soft trap not raised");

  property p_unmapped;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && i_fetch_valid && i_single_chip && !i_fetch_mapped
      |=> o_fetch_byte == EIU_SOFT_TRAP_OP && o_exc.soft_trap_opcode;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped fetch not trapped");

  property p_trap_rst;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && i_fetch_valid && i_fetch_addr <= RAM_TOP
      |=> (o_trap_reset == $past(i_trap_reset_sel)) && (o_exc.trap || $past(i_trap_reset_sel));
  endproperty
  a_trap_rst: assert property (p_trap_rst) else $error("trap response wrong");

  property p_undef_brk;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && i_fetch_valid && i_op_undefined && i_fetch_data != EIU_SOFT_TRAP_OP
      && i_fetch_mapped |=> o_exc.undef && o_break;
  endproperty
  a_undef_brk: assert property (p_undef_brk) else $error("undefined opcode missed");

  property p_pin_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
    !r.ctl[EIU_B_PFS] && !r.ltl[EIU_B_EF4] |=> !r.ltl[EIU_B_EF4];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("latch four set in port mode");

  property p_master;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && !r.enl[EIU_B_IMF] |=> !o_irq_req;
  endproperty
  a_master: assert property (p_master) else $error("request without master enable");

  property p_filt0;
    @(posedge i_clk) disable iff (!i_reset_n)
    $changed(r.lvl[EIU_P0]) |-> $past(r.cnt0) == EIU_N_SHORT - 8'h01;
  endproperty
  a_filt0: assert property (p_filt0) else $error("filter zero count wrong");

  property p_filt1;
    @(posedge i_clk) disable iff (!i_reset_n)
    $changed(r.lvl[EIU_P1]) |->
      $past(r.cnt1) == ($past(r.ctl[EIU_B_NTS]) ? EIU_N_MID : EIU_N_LONG) - 8'h01;
  endproperty
  a_filt1: assert property (p_filt1) else $error("filter one count wrong");

  property p_edge1;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_ce && $changed(r.lvl[EIU_P1]) && r.lvl[EIU_P1] == ~r.ctl[EIU_B_ES]
      && $stable(r.ctl) |-> r.ltl[EIU_B_EF5];
  endproperty
  a_edge1: assert property (p_edge1) else $error("edge one not latched");

endmodule

/* File: common/eiu_pkg.sv */
package eiu_pkg;
  // ==========================================================
  // System register offsets and window
  localparam logic [15:0] EIU_SFR_TOP = 16'h003F;
  localparam logic [5:0]  EIU_A_CTL   = 6'h37;  // ext_irq_control
  localparam logic [5:0]  EIU_A_ENL   = 6'h3A;  // irq_enable_low
  localparam logic [5:0]  EIU_A_ENH   = 6'h3B;  // irq_enable_high
  localparam logic [5:0]  EIU_A_LTL   = 6'h3C;  // irq_latch_low
  localparam logic [5:0]  EIU_A_LTH   = 6'h3D;  // irq_latch_high
  localparam logic [5:0]  EIU_A_PSW   = 6'h3F;  // program_status_word
  // ==========================================================
  // Field positions
  localparam int unsigned EIU_B_NTS  = 7;  // noise_time_select
  localparam int unsigned EIU_B_PFS  = 6;  // pin_func_select
  localparam int unsigned EIU_B_ES   = 1;  // edge_select
  localparam int unsigned EIU_B_IMF  = 0;  // master_irq_enable
  localparam int unsigned EIU_B_EF4  = 4;  // enable / latch four
  localparam int unsigned EIU_B_EF5  = 5;  // enable / latch five
  localparam int unsigned EIU_B_ENABLE_FLAG_FIFTEEN = 7;  // enable / latch fifteen (high byte)
  localparam logic [7:0]  EIU_CTL_MASK = 8'hC2;
  localparam logic [7:0]  EIU_RST_REG  = 8'h00;
  // ==========================================================
  // Opcode returned by a fetch from unmapped memory in single chip mode
  localparam logic [7:0] EIU_SOFT_TRAP_OP = 8'hFF;
  // ==========================================================
  // Filter times in high_freq_clock periods (i_clk is that clock)
  localparam int EIU_REJ_SHORT = 2;
  localparam int EIU_ACC_SHORT = 7;
  localparam int EIU_REJ_MID   = 15;
  localparam int EIU_ACC_MID   = 49;
  localparam int EIU_REJ_LONG  = 63;
  localparam int EIU_ACC_LONG  = 193;
  // Stable counts sit midway between reject and accept times
  localparam logic [7:0] EIU_N_SHORT = 8'((EIU_REJ_SHORT + EIU_ACC_SHORT) / 2);
  localparam logic [7:0] EIU_N_MID   = 8'((EIU_REJ_MID + EIU_ACC_MID) / 2);
  localparam logic [7:0] EIU_N_LONG  = 8'((EIU_REJ_LONG + EIU_ACC_LONG) / 2);
  // Pin indices
  localparam int unsigned EIU_P0 = 0;
  localparam int unsigned EIU_P1 = 1;
  localparam int unsigned EIU_P5 = 2;
  localparam logic [1:0]  EIU_SRC0 = 2'h0;
  localparam logic [1:0]  EIU_SRC1 = 2'h1;
  localparam logic [1:0]  EIU_SRC5 = 2'h2;
  // ==========================================================
  // Types
  typedef struct packed {
    logic soft_trap_opcode;
    logic undef;
    logic trap;
  } eiu_exc_s;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] enl;
    logic [7:0] enh;
    logic [7:0] ltl;
    logic [7:0] lth;
    logic [7:0] program_status_word;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic [7:0] cnt5;
    logic [7:0] rdata;
    logic [7:0] fbyte;
    eiu_exc_s   exc;
    logic       brk;
    logic       trst;
    logic       irq;
    logic [1:0] src;
  } eiu_state_s;
endpackage

/* File: sim/eiu_pin_src.sv */
`timescale 1ns/100ps
// ==========================================================
// Far side: sources on the three external interrupt pins
module eiu_pin_src (
  input  wire logic       i_clk,
  input  wire logic       i_go,     // Start one low pulse
  input  wire logic [1:0] i_idx,    // Pin to pulse
  input  wire logic [8:0] i_len,    // Low time in clocks
  output logic      [2:0] o_pins_n  // Pin levels
);
  logic [8:0] cnt_ff;  // Low cycles left
  logic [1:0] idx_ff;  // Pin being pulsed
  initial cnt_ff = 9'h000;
  initial idx_ff = 2'h0;
  // Whole-cycle pulses so the filter bounds are exact
  always @(posedge i_clk) begin
    if (i_go) begin
      cnt_ff <= i_len;
      idx_ff <= i_idx;
    end else if (cnt_ff != 9'h000) begin
      cnt_ff <= cnt_ff - 9'h001;
    end
  end
  // Released pins go back to the pull-up level
  always_comb begin
    o_pins_n = 3'h7;
    if (cnt_ff != 9'h000) begin
      o_pins_n[idx_ff] = 1'b0;
    end
  end
endmodule

/* File: sim/exception_and_ext_irq_unit_tb_top.sv */
`timescale 1ns/100ps
module exception_and_ext_irq_unit_tb_top import eiu_pkg::*;;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk, rst_n, rd, wr, fv, fmap, sc, und, tsel, iack, go, brk, trst, irq, pisi;
  logic [15:0] addr, faddr;
  logic [7:0]  wdat, fdat, rdat, fbyte, c, r;
  logic [1:0]  src, pidx, pi, me, due;
  logic [8:0]  plen, ln;
  logic [2:0]  pins_n;
  eiu_exc_s    ack, exc;
  logic [15:0] q[$];        // Expected results, oldest first
  logic [20:0] tab[11];     // Pin cases: ctl, pin, length, mid and end latch
  int          error_cnt, n_checks;
  eiu_unit u_eiu_unit (.i_clk(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdat), .o_reg_rdata(rdat), .i_fetch_valid(fv), .i_fetch_addr(faddr),
    .i_fetch_mapped(fmap), .i_fetch_data(fdat), .i_single_chip(sc), .i_op_undefined(und),
    .i_trap_reset_sel(tsel), .i_exc_ack(ack), .i_irq_ack(iack), .i_pins_n(pins_n), .o_fetch_byte(fbyte),
    .o_exc(exc), .o_break(brk), .o_trap_reset(trst), .o_irq_req(irq), .o_irq_src(src), .o_pin_is_irq(pisi));
  eiu_pin_src u_eiu_pin_src (.i_clk(clk), .i_go(go), .i_idx(pidx), .i_len(plen), .o_pins_n(pins_n));
  // ==========================================================
  // Checking
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A strobe taken at a rising edge makes a result due
  always @(posedge clk) due <= rd ? 2'h1 : fv ? 2'h2 : 2'h0;
  // Outputs are settled by the falling edge; compare with the oldest note
  always @(negedge clk) begin
    if (due == 2'h1) chk("rdata", q.pop_front(), {8'h00, rdat});
    if (due == 2'h2) chk("fetch", q.pop_front(), {3'h0, fbyte, exc, brk, trst});
  end
  task automatic give_verdict();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Drivers, all moving at the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One register access; a read notes its expected byte
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    if (!w) q.push_back({8'h00, d});
    addr = a;
    wdat = d;
    wr = w;
    rd = !w;
    tick(1);
    wr = 1'b0;
    rd = 1'b0;
    tick(1);
  endtask
  // Status is level, sampled directly; source only matters with a request
  task automatic stat(input logic [3:0] e);
    chk("status", {12'h000, e}, {12'h000, irq, irq ? src : 2'h0, pisi});
  endtask
  // One fetch, optionally acknowledging every pending exception after it
  task automatic fetch(input logic [15:0] a, input logic m, input logic [7:0] d, input logic u,
                       input logic t, input logic [12:0] e, input logic k);
    q.push_back({3'h0, e});
    faddr = a;
    fmap = m;
    fdat = d;
    und = u;
    tsel = t;
    fv = 1'b1;
    tick(1);
    fv = 1'b0;
    ack = k ? 3'h7 : 3'h0;
    tick(1);
    ack = 3'h0;
  endtask
  task automatic pulse(input logic [1:0] i, input logic [8:0] n);
    pidx = i;
    plen = n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask
  function automatic logic [7:0] lb(input logic [1:0] i);
    return i == 2'h0 ? 8'h10 : i == 2'h1 ? 8'h20 : 8'h80;
  endfunction
  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    error_cnt++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, rd, wr, fv, fmap, sc, und, tsel, iack, go, pidx, plen, addr, faddr, wdat, fdat} = '0;
    ack = 3'h0;
    sc = 1'b1;
    tab = '{{8'h00, 2'h0, 9'h014, 2'h0}, {8'h40, 2'h0, 9'h001, 2'h0}, {8'h40, 2'h0, 9'h007, 2'h1},
            {8'h40, 2'h2, 9'h001, 2'h0}, {8'h40, 2'h2, 9'h007, 2'h1}, {8'hC2, 2'h1, 9'h00E, 2'h0},
            {8'hC2, 2'h1, 9'h031, 2'h1}, {8'hC2, 2'h1, 9'h064, 2'h3}, {8'hC0, 2'h1, 9'h064, 2'h1},
            {8'h42, 2'h1, 9'h03E, 2'h0}, {8'h42, 2'h1, 9'h0C1, 2'h1}};
    void'($urandom(32'hBB7BDA22));
    tick(16);
    rst_n = 1'b1;
    tick(1);
    // Reset values, window edges, masks
    foreach (tab[i]) if (i < 6) acc(1'b0, 16'h0037 + 16'(i > 0) * (16'h0002 + 16'(i)), 8'h00);
    stat(4'h0);
    c = 8'($urandom());
    r = 8'($urandom());
    acc(1'b1, 16'h0037, c);
    acc(1'b0, 16'h0037, c & 8'hC2);
    acc(1'b1, 16'h003F, r);
    acc(1'b0, 16'h003F, r);
    acc(1'b1, 16'h0137, ~c);
    acc(1'b0, 16'h0037, c & 8'hC2);
    acc(1'b1, 16'h0038, 8'hFF);
    acc(1'b0, 16'h0038, 8'h00);
    acc(1'b1, 16'h003C, 8'hFF);
    acc(1'b0, 16'h003C, 8'h00);
    $display("Test registers done");
    // Fetch exceptions: swi stays pending while later ones arrive
    fetch(16'h1000, 1'b1, {1'b0, r[6:0]}, 1'b0, 1'b0, {1'b0, r[6:0], 5'h00}, 1'b1);
    fetch(16'h2000, 1'b0, 8'h12, 1'b0, 1'b0, {8'hFF, 5'h10}, 1'b0);
    fetch(16'h1234, 1'b1, 8'h5A, 1'b1, 1'b0, {8'h5A, 5'h1A}, 1'b1);
    fetch(16'h1000, 1'b1, 8'hFF, 1'b0, 1'b0, {8'hFF, 5'h10}, 1'b0);
    fetch(16'h0010, 1'b1, 8'h5A, 1'b0, 1'b0, {8'h5A, 5'h16}, 1'b1);
    fetch(16'h0030, 1'b1, 8'h33, 1'b0, 1'b1, {8'h33, 5'h01}, 1'b1);
    // Outside single chip mode an unmapped fetch passes its byte
    sc = 1'b0;
    fetch(16'h2000, 1'b0, 8'h12, 1'b0, 1'b0, {8'h12, 5'h00}, 1'b0);
    sc = 1'b1;
    $display("Test exceptions done");
    // Filters and edges; master stays off while the control byte changes
    foreach (tab[i]) begin
      {c, pi, ln, me} = tab[i];
      acc(1'b1, 16'h0037, c);
      tick(64);
      pulse(pi, ln);
      tick(int'(ln) / 2);
      acc(1'b0, pi[1] ? 16'h003D : 16'h003C, me[1] ? lb(pi) : 8'h00);
      tick(int'(ln) + 300);
      acc(1'b0, pi[1] ? 16'h003D : 16'h003C, me[0] ? lb(pi) : 8'h00);
      acc(1'b1, 16'h003C, 8'h00);
      acc(1'b1, 16'h003D, 8'h00);
    end
    $display("Test filters done");
    // Request gating and acceptance
    pulse(2'h0, 9'h010);
    tick(40);
    acc(1'b1, 16'h003A, 8'h10);
    stat(4'h1);
    acc(1'b1, 16'h003A, 8'h11);
    stat(4'h9);
    iack = 1'b1;
    tick(1);
    iack = 1'b0;
    tick(2);
    stat(4'h1);
    acc(1'b0, 16'h003C, 8'h00);
    acc(1'b0, 16'h003A, 8'h10);
    // Input five alone requests and names itself
    pulse(2'h2, 9'h010);
    tick(20);
    acc(1'b1, 16'h003B, 8'h80);
    acc(1'b1, 16'h003A, 8'h01);
    stat(4'hD);
    $display("Test requests done");
    give_verdict();
  end
endmodule
